// [hdl/isab_pkg.sv]
// register map and field positions for the status, address, mask and divider block
package isab_pkg;
  localparam logic [7:0] STAT_OFF      = 8'h00;
  localparam logic [7:0] ADDR_OFF      = 8'h04;
  localparam logic [7:0] MASK_OFF      = 8'h08;
  localparam logic [7:0] BRG_OFF       = 8'h0c;
  localparam logic [7:0] CTRL_OFF      = 8'h10;
  localparam logic [7:0] TXB_OFF       = 8'h14;
  localparam logic [7:0] RXB_OFF       = 8'h18;
  localparam int         ACK_BIT       = 15;
  localparam int         TRS_BIT       = 14;
  localparam int         BCL_BIT       = 10;
  localparam int         GC_BIT        = 9;
  localparam int         A10_BIT       = 8;
  localparam int         WCOL_BIT      = 7;
  localparam int         OV_BIT        = 6;
  localparam int         DA_BIT        = 5;
  localparam int         P_BIT         = 4;
  localparam int         S_BIT         = 3;
  localparam int         RW_BIT        = 2;
  localparam int         RBF_BIT       = 1;
  localparam int         TBF_BIT       = 0;
  localparam int         CTRL_ON_BIT   = 15;
  localparam int         CTRL_ADDRESS_WIDTH_SELECT_BIT = 10;
  localparam logic [9:0]  ADDR_RST     = 10'h000;
  localparam logic [9:0]  MASK_RST     = 10'h000;
  localparam logic [11:0] BRG_RST      = 12'h000;
  localparam logic [1:0]  RESP_OKAY    = 2'b00;
  localparam logic [1:0]  RESP_SLVERR  = 2'b10;
endpackage

// [hdl/isab_top.sv]
// status, own address, address mask and bit rate divider with an axi4-lite slave
//
// Chosen here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ns
// Notes on behaviour
// RQ1: status shows last sampled acknowledge, 1 meaning not acknowledged.
// RQ2: transmit-active flag is 1 during master byte plus acknowledge slot.
// RQ3: collision flag set on master bus collision, writable, cleared when disabled.
// RQ4: general call flag set on general call address, cleared at stop.
// RQ5: ten-bit match flag set on ten-bit match, cleared at stop.
// RQ6: writing transmit buffer while busy sets write clash flag until cleared.
// RQ7: byte arriving with receive buffer full sets overflow, software clears it.
// RQ8: slave data/address flag shows kind of last byte.
// RQ9: stop flag updated on start, reset or stop; cleared when disabled.
// RQ10: start flag updated on start, reset or stop; cleared when disabled.
// RQ11: slave direction flag taken from address byte, 1 for read.
// RQ12: receive full flag set on complete byte, zero when buffer empty.
// RQ13: transmit full flag set while buffer holds data, cleared on completion.
// RQ14: ten-bit own address register, resets to zero.
// RQ15: mask bit one makes that address bit a don't care.
// RQ16: mask bit zero requires address bit equal to own address.
// RQ17: mask bits nine, eight and zero used only in ten-bit mode.
// RQ18: twelve-bit divider of the clock makes the master bit rate tick.
// RQ19: address width select chooses ten-bit or seven-bit own address.
// RQ20: unimplemented upper bits read as zero and ignore writes.
module isab_top (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RST_N,
  // axi4-lite write address, data and response
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  // axi4-lite read
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  // bus engine events, same clock
  input  wire logic        ACK_SAMPLE,
  input  wire logic        ACK_NACK,
  input  wire logic        MASTER_TX_BUSY,
  input  wire logic        COLLISION_EVT,
  input  wire logic        START_EVT,
  input  wire logic        STOP_EVT,
  input  wire logic        RESET_EVT,
  input  wire logic        ADDR_BYTE_EVT,
  input  wire logic        DATA_BYTE_EVT,
  input  wire logic        SLAVE_DIR_READ,
  input  wire logic        RX_BYTE_EVT,
  input  wire logic [7:0]  RX_BYTE,
  input  wire logic        TX_DONE_EVT,
  input  wire logic        MODULE_BUSY,
  input  wire logic [9:0]  IN_ADDR,
  input  wire logic        IN_ADDR_CHECK,
  // outputs to bus engine
  output logic             ADDR_MATCH,
  output logic             GEN_CALL_MATCH,
  output logic             BAUD_TICK,
  output logic             MODULE_ON,
  output logic             TX_LOAD,
  output logic [7:0]       TX_BYTE
);
  logic        aw_hold_reg, aw_hold_next, w_hold_reg, w_hold_next;
  logic [7:0]  awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0]  wstrb_reg, wstrb_next;
  logic        bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0]  bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic        arready_reg, arready_next;
  logic [15:0] stat_reg, stat_next;
  logic [9:0]  addr_reg, addr_next, mask_reg, mask_next;
  logic [11:0] brg_reg, brg_next, baud_cnt_reg, baud_cnt_next;
  logic        on_reg, on_next, address_width_select_reg, address_width_select_next;
  logic [7:0]  txb_reg, txb_next, rxb_reg, rxb_next;
  logic        tick_reg, tick_next, match_reg, match_next, gc_reg, gc_next;
  logic        load_reg, load_next;
  logic        wr_go, rd_go;
  logic [31:0] wd;
  logic [9:0]  cmp_mask, diff;

  assign wr_go = aw_hold_reg && w_hold_reg && !bvalid_reg;
  assign rd_go = S_AXI_ARVALID && arready_reg;
  assign wd    = wdata_reg;

  // address compare; seven-bit mode ignores mask bits 9, 8 and 0
  always_comb begin
    cmp_mask = ~mask_reg; // RQ15 RQ16
    if (!address_width_select_reg) begin
      cmp_mask = cmp_mask & 10'h0fe; // RQ17 RQ19
    end
    diff = (IN_ADDR ^ addr_reg) & cmp_mask;
  end

  always_comb begin
    aw_hold_next  = aw_hold_reg;
    w_hold_next   = w_hold_reg;
    awaddr_next   = awaddr_reg;
    wdata_next    = wdata_reg;
    wstrb_next    = wstrb_reg;
    bvalid_next   = bvalid_reg;
    bresp_next    = bresp_reg;
    rvalid_next   = rvalid_reg;
    rresp_next    = rresp_reg;
    rdata_next    = rdata_reg;
    arready_next  = arready_reg;
    stat_next     = stat_reg;
    addr_next     = addr_reg;
    mask_next     = mask_reg;
    brg_next      = brg_reg;
    on_next       = on_reg;
    address_width_select_next     = address_width_select_reg;
    txb_next      = txb_reg;
    rxb_next      = rxb_reg;
    load_next     = 1'b0;
    match_next    = IN_ADDR_CHECK && (diff == 10'h000);
    gc_next       = IN_ADDR_CHECK && (IN_ADDR[7:0] == 8'h00);
    // bit rate divider; zero divider ticks every cycle while the module is on
    tick_next     = 1'b0;
    baud_cnt_next = baud_cnt_reg + 12'h001;
    if (baud_cnt_reg >= brg_reg) begin
      baud_cnt_next = 12'h000;
      tick_next     = on_reg; // RQ18
    end
    if (S_AXI_AWVALID && !aw_hold_reg) begin
      aw_hold_next = 1'b1;
      awaddr_next  = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && !w_hold_reg) begin
      w_hold_next = 1'b1;
      wdata_next  = S_AXI_WDATA;
      wstrb_next  = S_AXI_WSTRB;
    end
    if (bvalid_reg && S_AXI_BREADY) begin
      bvalid_next = 1'b0;
    end
    // software writes first, hardware events after so a set wins
    if (wr_go) begin
      aw_hold_next = 1'b0;
      w_hold_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = isab_pkg::RESP_OKAY;
      case (awaddr_reg)
        isab_pkg::STAT_OFF: begin
          if (wstrb_reg[1]) begin
            stat_next[isab_pkg::BCL_BIT] = wd[isab_pkg::BCL_BIT]; // RQ3
          end
          if (wstrb_reg[0]) begin
            stat_next[isab_pkg::WCOL_BIT] = wd[isab_pkg::WCOL_BIT]; // RQ6
            stat_next[isab_pkg::OV_BIT]   = wd[isab_pkg::OV_BIT]; // RQ7
            stat_next[isab_pkg::P_BIT]    = wd[isab_pkg::P_BIT];
            stat_next[isab_pkg::S_BIT]    = wd[isab_pkg::S_BIT];
          end
        end
        isab_pkg::ADDR_OFF: begin
          if (wstrb_reg[0]) addr_next[7:0] = wd[7:0]; // RQ14
          if (wstrb_reg[1]) addr_next[9:8] = wd[9:8]; // RQ20
        end
        isab_pkg::MASK_OFF: begin
          if (wstrb_reg[0]) mask_next[7:0] = wd[7:0];
          if (wstrb_reg[1]) mask_next[9:8] = wd[9:8];
        end
        isab_pkg::BRG_OFF: begin
          if (wstrb_reg[0]) brg_next[7:0]  = wd[7:0]; // RQ18
          if (wstrb_reg[1]) brg_next[11:8] = wd[11:8];
        end
        isab_pkg::CTRL_OFF: begin
          if (wstrb_reg[1]) begin
            on_next   = wd[isab_pkg::CTRL_ON_BIT];
            address_width_select_next = wd[isab_pkg::CTRL_ADDRESS_WIDTH_SELECT_BIT]; // RQ19
          end
        end
        isab_pkg::TXB_OFF: begin
          if (wstrb_reg[0]) begin
            if (MODULE_BUSY || stat_reg[isab_pkg::TBF_BIT]) begin
              stat_next[isab_pkg::WCOL_BIT] = 1'b1; // RQ6
            end else begin
              txb_next = wd[7:0];
              load_next = 1'b1;
              stat_next[isab_pkg::TBF_BIT] = 1'b1; // RQ13
            end
          end
        end
        isab_pkg::RXB_OFF: begin
        end
        default: begin
          bresp_next = isab_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (rvalid_reg && S_AXI_RREADY) begin
      rvalid_next  = 1'b0;
      arready_next = 1'b1;
    end
    if (rd_go) begin
      arready_next = 1'b0;
      rvalid_next  = 1'b1;
      rresp_next   = isab_pkg::RESP_OKAY;
      rdata_next   = 32'h0000_0000; // RQ20
      case (S_AXI_ARADDR)
        isab_pkg::STAT_OFF: rdata_next[15:0] = stat_reg;
        isab_pkg::ADDR_OFF: rdata_next[9:0]  = addr_reg;
        isab_pkg::MASK_OFF: rdata_next[9:0]  = mask_reg;
        isab_pkg::BRG_OFF:  rdata_next[11:0] = brg_reg;
        isab_pkg::CTRL_OFF: begin
          rdata_next[isab_pkg::CTRL_ON_BIT]   = on_reg;
          rdata_next[isab_pkg::CTRL_ADDRESS_WIDTH_SELECT_BIT] = address_width_select_reg;
        end
        isab_pkg::TXB_OFF:  rdata_next[7:0]  = txb_reg;
        isab_pkg::RXB_OFF: begin
          rdata_next[7:0] = rxb_reg;
          stat_next[isab_pkg::RBF_BIT] = 1'b0; // RQ12
        end
        default: rresp_next = isab_pkg::RESP_SLVERR;
      endcase
    end
    // hardware events
    if (ACK_SAMPLE) stat_next[isab_pkg::ACK_BIT] = ACK_NACK; // RQ1
    stat_next[isab_pkg::TRS_BIT] = MASTER_TX_BUSY; // RQ2
    if (COLLISION_EVT) stat_next[isab_pkg::BCL_BIT] = 1'b1; // RQ3
    if (STOP_EVT) begin
      stat_next[isab_pkg::GC_BIT]  = 1'b0; // RQ4
      stat_next[isab_pkg::A10_BIT] = 1'b0; // RQ5
    end
    if (gc_reg) stat_next[isab_pkg::GC_BIT] = 1'b1; // RQ4
    if (match_reg && address_width_select_reg) stat_next[isab_pkg::A10_BIT] = 1'b1; // RQ5
    if (ADDR_BYTE_EVT) begin
      stat_next[isab_pkg::DA_BIT] = 1'b0; // RQ8
      stat_next[isab_pkg::RW_BIT] = SLAVE_DIR_READ; // RQ11
    end
    if (DATA_BYTE_EVT) stat_next[isab_pkg::DA_BIT] = 1'b1; // RQ8
    if (START_EVT || STOP_EVT || RESET_EVT) begin
      stat_next[isab_pkg::P_BIT] = STOP_EVT; // RQ9
      stat_next[isab_pkg::S_BIT] = START_EVT && !STOP_EVT; // RQ10
    end
    // a buffer read in the same cycle frees it, so the new byte is kept
    if (RX_BYTE_EVT) begin
      if (stat_next[isab_pkg::RBF_BIT]) begin
        stat_next[isab_pkg::OV_BIT] = 1'b1; // RQ7
      end else begin
        rxb_next = RX_BYTE;
        stat_next[isab_pkg::RBF_BIT] = 1'b1; // RQ12
      end
    end
    if (TX_DONE_EVT && !load_next) stat_next[isab_pkg::TBF_BIT] = 1'b0; // RQ13
    // module disable clears these flags
    if (!on_reg) begin
      stat_next[isab_pkg::BCL_BIT] = 1'b0; // RQ3
      stat_next[isab_pkg::P_BIT]   = 1'b0; // RQ9
      stat_next[isab_pkg::S_BIT]   = 1'b0; // RQ10
    end
    stat_next[13:11] = 3'b000; // RQ20
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      aw_hold_reg  <= 1'b0;
      w_hold_reg   <= 1'b0;
      awaddr_reg   <= 8'h00;
      wdata_reg    <= 32'h0000_0000;
      wstrb_reg    <= 4'h0;
      bvalid_reg   <= 1'b0;
      bresp_reg    <= 2'b00;
      rvalid_reg   <= 1'b0;
      rresp_reg    <= 2'b00;
      rdata_reg    <= 32'h0000_0000;
      arready_reg  <= 1'b1;
      stat_reg     <= 16'h0000;
      addr_reg     <= isab_pkg::ADDR_RST;
      mask_reg     <= isab_pkg::MASK_RST;
      brg_reg      <= isab_pkg::BRG_RST;
      baud_cnt_reg <= 12'h000;
      on_reg       <= 1'b0;
      address_width_select_reg     <= 1'b0;
      txb_reg      <= 8'h00;
      rxb_reg      <= 8'h00;
      tick_reg     <= 1'b0;
      match_reg    <= 1'b0;
      gc_reg       <= 1'b0;
      load_reg     <= 1'b0;
    end else begin
      aw_hold_reg  <= aw_hold_next;
      w_hold_reg   <= w_hold_next;
      awaddr_reg   <= awaddr_next;
      wdata_reg    <= wdata_next;
      wstrb_reg    <= wstrb_next;
      bvalid_reg   <= bvalid_next;
      bresp_reg    <= bresp_next;
      rvalid_reg   <= rvalid_next;
      rresp_reg    <= rresp_next;
      rdata_reg    <= rdata_next;
      arready_reg  <= arready_next;
      stat_reg     <= stat_next;
      addr_reg     <= addr_next;
      mask_reg     <= mask_next;
      brg_reg      <= brg_next;
      baud_cnt_reg <= baud_cnt_next;
      on_reg       <= on_next;
      address_width_select_reg     <= address_width_select_next;
      txb_reg      <= txb_next;
      rxb_reg      <= rxb_next;
      tick_reg     <= tick_next;
      match_reg    <= match_next;
      gc_reg       <= gc_next;
      load_reg     <= load_next;
    end
  end

  assign S_AXI_AWREADY  = !aw_hold_reg;
  assign S_AXI_WREADY   = !w_hold_reg;
  assign S_AXI_BVALID   = bvalid_reg;
  assign S_AXI_BRESP    = bresp_reg;
  assign S_AXI_ARREADY  = arready_reg;
  assign S_AXI_RVALID   = rvalid_reg;
  assign S_AXI_RRESP    = rresp_reg;
  assign S_AXI_RDATA    = rdata_reg;
  assign ADDR_MATCH     = match_reg;
  assign GEN_CALL_MATCH = gc_reg;
  assign BAUD_TICK      = tick_reg;
  assign MODULE_ON      = on_reg;
  assign TX_LOAD        = load_reg;
  assign TX_BYTE        = txb_reg;

  // assertions
  property p_ack;
    @(posedge CLK) disable iff (!RST_N)
      ACK_SAMPLE |=> stat_reg[isab_pkg::ACK_BIT] == $past(ACK_NACK);
  endproperty
  a_ack: assert property (p_ack) else $error("ack status wrong"); // RQ1
  property p_trs;
    @(posedge CLK) disable iff (!RST_N)
      1'b1 |=> stat_reg[isab_pkg::TRS_BIT] == $past(MASTER_TX_BUSY);
  endproperty
  a_trs: assert property (p_trs) else $error("tx active wrong"); // RQ2
  property p_bcl;
    @(posedge CLK) disable iff (!RST_N)
      (COLLISION_EVT && on_reg) |=> stat_reg[isab_pkg::BCL_BIT];
  endproperty
  a_bcl: assert property (p_bcl) else $error("collision not set"); // RQ3
  property p_off;
    @(posedge CLK) disable iff (!RST_N)
      !on_reg |=> !stat_reg[isab_pkg::P_BIT] && !stat_reg[isab_pkg::S_BIT];
  endproperty
  a_off: assert property (p_off) else $error("flags kept when off"); // RQ9
  property p_stop;
    @(posedge CLK) disable iff (!RST_N)
      (STOP_EVT && on_reg) |=> stat_reg[isab_pkg::P_BIT] && !stat_reg[isab_pkg::S_BIT];
  endproperty
  a_stop: assert property (p_stop) else $error("stop flag wrong"); // RQ10
  property p_ov;
    @(posedge CLK) disable iff (!RST_N)
      (RX_BYTE_EVT && stat_reg[isab_pkg::RBF_BIT] &&
       !(rd_go && S_AXI_ARADDR == isab_pkg::RXB_OFF)) |=> stat_reg[isab_pkg::OV_BIT];
  endproperty
  a_ov: assert property (p_ov) else $error("overflow not set"); // RQ7
  property p_rbf;
    @(posedge CLK) disable iff (!RST_N)
      (RX_BYTE_EVT && !stat_reg[isab_pkg::RBF_BIT]) |=>
        stat_reg[isab_pkg::RBF_BIT] && rxb_reg == $past(RX_BYTE);
  endproperty
  a_rbf: assert property (p_rbf) else $error("receive not stored"); // RQ12
  property p_match;
    @(posedge CLK) disable iff (!RST_N)
      (IN_ADDR_CHECK && !address_width_select_reg && ((IN_ADDR ^ addr_reg) & ~mask_reg & 10'h0fe) == 10'h000)
        |=> ADDR_MATCH;
  endproperty
  a_match: assert property (p_match) else $error("seven-bit match missed"); // RQ17
  property p_tick;
    @(posedge CLK) disable iff (!RST_N)
      (on_reg && brg_reg == 12'h000 && $past(on_reg) && $past(brg_reg) == 12'h000)
        |=> BAUD_TICK;
  endproperty
  a_tick: assert property (p_tick) else $error("divider tick missing"); // RQ18
  property p_tick_gap;
    @(posedge CLK) disable iff (!RST_N)
      (BAUD_TICK && brg_reg != 12'h000) |=> !BAUD_TICK;
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("divider tick too soon"); // RQ18
endmodule

// [tb/isab_engine.sv]
// bus engine model that raises the event pulses seen by the status block
`timescale 1ns/1ns
module isab_engine (
  // clock
  input  wire logic       clk,
  // events and their qualifiers
  output logic            ack_sample,
  output logic            ack_nack,
  output logic            collision_evt,
  output logic            start_evt,
  output logic            stop_evt,
  output logic            reset_evt,
  output logic            addr_byte_evt,
  output logic            data_byte_evt,
  output logic            slave_dir_read,
  output logic            rx_byte_evt,
  output logic [7:0]      rx_byte,
  output logic            tx_done_evt
);
  logic [8:0] ev_reg   = 9'h000;
  logic       flag_reg = 1'b0;
  logic [7:0] data_reg = 8'h00;
  assign {tx_done_evt, rx_byte_evt, data_byte_evt, addr_byte_evt, reset_evt,
          stop_evt, start_evt, collision_evt, ack_sample} = ev_reg;
  assign ack_nack       = flag_reg;
  assign slave_dir_read = flag_reg;
  assign rx_byte        = data_reg;
  // one-cycle event; a byte may come while the buffer is still full
  task pulse(input logic [8:0] m, input logic f, input logic [7:0] d);
    @(posedge clk);
    ev_reg   <= m;
    flag_reg <= f;
    data_reg <= d;
    @(posedge clk);
    ev_reg   <= 9'h000;
    // released qualifiers show the inverse so stale values cannot pass
    flag_reg <= ~f;
    data_reg <= ~d;
  endtask
endmodule

// [tb/isab_top_tb.sv]
// self-checking bench for the status, address, mask and divider block
`timescale 1ns/1ns
module isab_top_tb;
  localparam logic [1:0] OK = isab_pkg::RESP_OKAY;
  localparam logic [1:0] ER = isab_pkg::RESP_SLVERR;
  localparam logic [7:0] SO = isab_pkg::STAT_OFF;
  localparam logic [7:0] CO = isab_pkg::CTRL_OFF;
  logic        clk = 1'b0, rst_n = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        tx_busy = 1'b0, mod_busy = 1'b0, chk_en = 1'b0;
  logic [9:0]  in_addr = 10'h000;
  logic        awready, wready, bvalid, arready, rvalid, addr_match, gen_call;
  logic        baud_tick, module_on, tx_load, acks, ackn, colv, stav, stov, rstv;
  logic        adrv, datv, dirr, rxv, txdv;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [7:0]  tx_byte, rxb, last_tx = 8'h00;
  logic [34:0] exp_q[$];
  logic [34:0] e;
  logic [31:0] st = 32'h0;
  logic [15:0] lfsr_s = 16'h5d61;
  logic [7:0]  offs[4] = '{isab_pkg::STAT_OFF, isab_pkg::ADDR_OFF, isab_pkg::MASK_OFF,
                           isab_pkg::BRG_OFF};
  logic [31:0] wm[4] = '{32'h0, 32'h3ff, 32'h3ff, 32'hfff};
  int          errors = 0;
  int          n_compared = 0;

  always #5 clk = ~clk;

  isab_engine eng (.clk(clk), .ack_sample(acks), .ack_nack(ackn), .collision_evt(colv),
    .start_evt(stav), .stop_evt(stov), .reset_evt(rstv), .addr_byte_evt(adrv),
    .data_byte_evt(datv), .slave_dir_read(dirr), .rx_byte_evt(rxv), .rx_byte(rxb),
    .tx_done_evt(txdv));

  isab_top dut (.CLK(clk), .RST_N(rst_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .ACK_SAMPLE(acks), .ACK_NACK(ackn), .MASTER_TX_BUSY(tx_busy), .COLLISION_EVT(colv),
    .START_EVT(stav), .STOP_EVT(stov), .RESET_EVT(rstv), .ADDR_BYTE_EVT(adrv),
    .DATA_BYTE_EVT(datv), .SLAVE_DIR_READ(dirr), .RX_BYTE_EVT(rxv), .RX_BYTE(rxb),
    .TX_DONE_EVT(txdv), .MODULE_BUSY(mod_busy), .IN_ADDR(in_addr), .IN_ADDR_CHECK(chk_en),
    .ADDR_MATCH(addr_match), .GEN_CALL_MATCH(gen_call), .BAUD_TICK(baud_tick),
    .MODULE_ON(module_on), .TX_LOAD(tx_load), .TX_BYTE(tx_byte));

  task finish_test;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task chk_bus(input logic [34:0] got, input logic [34:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t bus got %h exp %h", $time, got, exp);
    end
  endtask

  task chk_sig(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t sig got %h exp %h", $time, got, exp);
    end
  endtask

  task tmo(input int n);
    if (n > 200) begin
      errors++;
      $display("[FAIL] t=%0t wait got %h exp %h", $time, n, 200);
      finish_test;
    end
  endtask

  function logic [31:0] rnd();
    for (int i = 0; i < 16; i++)
      lfsr_s = {lfsr_s[14:0], lfsr_s[15] ^ lfsr_s[13] ^ lfsr_s[12] ^ lfsr_s[10]};
    return {lfsr_s, lfsr_s[7:0], lfsr_s[15:8]};
  endfunction

  // write: both channels offered together, bready held until bvalid is seen
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    exp_q.push_back({1'b1, r, 32'h0});
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      tmo(++n);
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    exp_q.push_back({1'b0, r, d});
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
      tmo(++n);
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask

  task rs;
    rd(SO, st, OK);
  endtask

  // response watcher: data is only meaningful on an okay read
  always @(posedge clk) begin
    if (tx_load === 1'b1) last_tx <= tx_byte;
    if ((bvalid & bready) === 1'b1 || (rvalid & rready) === 1'b1) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 35'h7ffffffff;
      if (bvalid === 1'b1) chk_bus({1'b1, bresp, 32'h0}, e);
      else chk_bus({1'b0, rresp, (e[33:32] == OK) ? rdata : e[31:0]}, e);
    end
  end

  initial begin
    logic [31:0] d;
    int k;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) rd(offs[i], 32'h0, OK);
    for (int i = 1; i < 4; i++) begin
      d = rnd();
      wr(offs[i], d, OK);
      rd(offs[i], d & wm[i], OK);
    end
    wr(8'h1c, 32'h1, ER);
    rd(8'h1c, 32'h0, ER);
    wr(CO, 32'h8000, OK);
    chk_sig(32'(module_on), 32'h1);
    eng.pulse(9'h004, 1'b0, 8'h00);
    st[3] = 1'b1;
    rs();
    eng.pulse(9'h008, 1'b0, 8'h00);
    st[3] = 1'b0;
    st[4] = 1'b1;
    rs();
    eng.pulse(9'h010, 1'b0, 8'h00);
    st[4] = 1'b0;
    eng.pulse(9'h002, 1'b0, 8'h00);
    eng.pulse(9'h004, 1'b0, 8'h00);
    st[10] = 1'b1;
    st[3] = 1'b1;
    rs();
    wr(CO, 32'h0, OK);
    chk_sig(32'(module_on), 32'h0);
    st[10] = 1'b0;
    st[3] = 1'b0;
    rs();
    wr(CO, 32'h8000, OK);
    eng.pulse(9'h001, 1'b1, 8'h00);
    tx_busy <= 1'b1;
    eng.pulse(9'h020, 1'b1, 8'h00);
    st[15] = 1'b1;
    st[14] = 1'b1;
    st[2] = 1'b1;
    rs();
    tx_busy <= 1'b0;
    eng.pulse(9'h001, 1'b0, 8'h00);
    eng.pulse(9'h040, 1'b0, 8'h00);
    eng.pulse(9'h080, 1'b0, 8'h5a);
    eng.pulse(9'h080, 1'b0, 8'h33);
    st[15:14] = 2'b00;
    st[5] = 1'b1;
    st[1] = 1'b1;
    st[6] = 1'b1;
    rs();
    rd(isab_pkg::RXB_OFF, 32'h5a, OK);
    st[1] = 1'b0;
    wr(SO, 32'h0, OK);
    st[6] = 1'b0;
    mod_busy <= 1'b1;
    wr(isab_pkg::TXB_OFF, 32'ha5, OK);
    mod_busy <= 1'b0;
    st[7] = 1'b1;
    wr(isab_pkg::TXB_OFF, 32'h3c, OK);
    st[0] = 1'b1;
    rs();
    chk_sig(32'(last_tx), 32'h3c);
    eng.pulse(9'h100, 1'b0, 8'h00);
    st[0] = 1'b0;
    rs();
    wr(SO, 32'h0, OK);
    st[7] = 1'b0;
    wr(isab_pkg::ADDR_OFF, 32'h2a5, OK);
    wr(isab_pkg::MASK_OFF, 32'h001, OK);
    wr(CO, 32'h8400, OK);
    rd(CO, 32'h8400, OK);
    chk_en <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (i == 3) wr(CO, 32'h8000, OK);
      in_addr <= (i == 0) ? 10'h2a4 : (i == 2) ? 10'h000 : 10'h0a5;
      repeat (2) @(posedge clk);
      d = (i == 0 || i == 3) ? 32'h2 : (i == 2) ? 32'h1 : 32'h0;
      chk_sig(32'({addr_match, gen_call}), d);
    end
    chk_en <= 1'b0;
    st[8] = 1'b1;
    st[9] = 1'b1;
    rs();
    eng.pulse(9'h008, 1'b0, 8'h00);
    st[9:8] = 2'b00;
    st[4] = 1'b1;
    rs();
    wr(isab_pkg::BRG_OFF, 32'h3, OK);
    k = 0;
    while (baud_tick !== 1'b1) begin
      @(posedge clk);
      tmo(++k);
    end
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (baud_tick !== 1'b1 && k < 50);
    chk_sig(k, 32'h4);
    finish_test;
  end
endmodule
